// ---- pkg/dmu_regs.vh ----
// Address map, register offsets and field positions of the data memory unit
`ifndef DMU_REGS_VH
`define DMU_REGS_VH
`define SEG_DATA        4'hd
`define SEG_EMPTY       4'h9
`define SRAM_BASE       32'hd0000000
`define SRAM_LAST       32'hd0007fff
`define SBY_BASE        32'hd0008000
`define SBY_LAST        32'hd000ffff
`define SRAM_AW         13
`define SBY_AW          11
`define REGS_BASE       32'hd7ffff00
`define REGS_LAST       32'hd7ffffff
`define OFS_CTRL        8'h10
`define OFS_SYNC        8'h18
`define OFS_ASYNC       8'h20
`define CTRL_RST        8'h00
`define FLAGS_RST       6'h00
`define BIT_LD_RANGE    0
`define BIT_ST_RANGE    1
`define BIT_LD_BUS      2
`define BIT_ST_BUS      3
`define BIT_LD_REG      4
`define BIT_ST_REG      5
`endif

// ---- hdl/dmu_ram.v ----
// Single-port word memory with byte writes, one cycle read latency
`default_nettype none
module dmu_ram #(
  parameter AW = 13
) (
  input  wire          clk,
  input  wire          en,
  input  wire          we,
  input  wire [3:0]    be,
  input  wire [AW-1:0] addr,
  input  wire [31:0]   wdata,
  output reg  [31:0]   rdata
);
  reg [31:0] mem [0:(1<<AW)-1];
  integer i;

  // Byte lane write and registered read
  always @(posedge clk) begin
    if (en) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (we && be[i])
          mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// ---- hdl/dmu_flags.v ----
// Trap flag register: sticky sets, cleared on supervisor read
`default_nettype none
`include "dmu_regs.vh"
module dmu_flags (
  input  wire       clk,
  input  wire       arst_n,
  input  wire [5:0] set,
  input  wire       clr,
  output reg  [5:0] flags_q
);
  // Set wins over the clear of the same cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      flags_q <= `FLAGS_RST; // [R21]
    else
      flags_q <= (clr ? 6'h00 : flags_q) | set; // [R12] [R13]
  end
endmodule
`default_nettype wire

// ---- hdl/data_memory_unit.v ----
// Data memory unit: SRAMs, address decode, bus slave, bus master, trap flags
//
// Function
// [R1] Bus slave takes only half-word and word
// [R2] Misaligned bus slave access gets bus error
// [R3] Main SRAM is 32 KB at segment 13 base
// [R4] Standby SRAM 8 KB, mirrored four times
// [R5] Reserved space: range trap or bus error
// [R6] Processor sizes 8 to 64, half-word aligned; code serves 8 to 32, size 3 as one word, alignment unchecked
// [R7] Bus slave serves user and supervisor
// [R8] Master outward for processor, slave inward
// [R9] Bus read-modify-write is locked, indivisible
// [R10] Load errors synchronous, store errors asynchronous
// [R11] Every error has flags in both registers
// [R12] Error drives trap and sets its flag
// [R13] Supervisor read returns flags, then clears
// [R14] User read returns flags, keeps them
// [R15] Outbound bus error sets load/store flag
// [R16] Unmapped segment 13 access: range trap
// [R17] Any segment 9 access: range trap
// [R18] Range error sets load or store flag
// [R19] Bad register access: register error trap
// [R20] Reserved register words: zero, no error
// [R21] Reset clears both flag registers
`default_nettype none
`include "dmu_regs.vh"
module data_memory_unit (
  input  wire        CLK,
  input  wire        ARST_N,
  // Processor load/store side (64-bit in two word beats not needed)
  input  wire        LS_REQ,
  input  wire        LS_WE,
  input  wire [31:0] LS_ADDR,
  input  wire [1:0]  LS_SIZE,
  input  wire [31:0] LS_WDATA,
  input  wire        LS_SUPER,
  input  wire        LS_ENDINIT_OK,
  output reg         LS_ACK,
  output reg  [31:0] LS_RDATA,
  output reg         SYNC_TRAP,
  output reg         ASYNC_TRAP,
  // System bus slave (Wishbone classic)
  input  wire        S_CYC_I,
  input  wire        S_STB_I,
  input  wire        S_WE_I,
  input  wire        S_LOCK_I,
  input  wire [31:0] S_ADR_I,
  input  wire [3:0]  S_SEL_I,
  input  wire [31:0] S_DAT_I,
  output reg  [31:0] S_DAT_O,
  output reg         S_ACK_O,
  output reg         S_ERR_O,
  // System bus master (Wishbone classic)
  output reg         M_CYC_O,
  output reg         M_STB_O,
  output reg         M_WE_O,
  output reg  [31:0] M_ADR_O,
  output reg  [3:0]  M_SEL_O,
  output reg  [31:0] M_DAT_O,
  input  wire [31:0] M_DAT_I,
  input  wire        M_ACK_I,
  input  wire        M_ERR_I
);
  localparam ST_IDLE = 3'd0;
  localparam ST_PRD  = 3'd1;
  localparam ST_PDONE = 3'd2;
  localparam ST_SRD  = 3'd3;
  localparam ST_SDONE = 3'd4;
  localparam ST_MST  = 3'd5;
  localparam ST_END  = 3'd6;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [7:0]  ctrl_q;
  reg         p_sel_sram_q;
  reg  [1:0]  p_lo_q;
  reg  [1:0]  p_size_q;
  reg         s_lock_q;
  reg         s_sel_sram_q;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, shared by both requesters
  wire        s_req     = S_CYC_I & S_STB_I & ~S_ACK_O & ~S_ERR_O;
  wire        p_take    = LS_REQ & (state_q == ST_IDLE) & ~s_lock_q;
  wire        s_take    = s_req & (state_q == ST_IDLE) & ~p_take;
  wire [31:0] d_addr    = p_take ? LS_ADDR : S_ADR_I;
  wire        in_seg13  = d_addr[31:28] == `SEG_DATA;
  wire        in_seg9   = d_addr[31:28] == `SEG_EMPTY; // [R17]
  wire        hit_sram  = d_addr >= `SRAM_BASE && d_addr <= `SRAM_LAST; // [R3]
  wire        hit_sby   = d_addr >= `SBY_BASE && d_addr <= `SBY_LAST; // [R4]
  wire        hit_regs  = d_addr >= `REGS_BASE && d_addr <= `REGS_LAST;
  wire        hit_mem   = hit_sram | hit_sby;
  // Reserved space in segment 13, plus all of segment 9
  wire        range_err = (in_seg13 & ~hit_mem & ~hit_regs) | in_seg9; // [R16]
  wire        local_hit = in_seg13 | in_seg9;

  ////////////////////////////////////////////////////////////////////////
  // Processor side checks: width from size, byte enables
  reg  [3:0]  p_be;
  always @* begin
    case (LS_SIZE)
      2'd0:    p_be = 4'h1 << LS_ADDR[1:0];
      2'd1:    p_be = LS_ADDR[1] ? 4'hc : 4'h3;
      default: p_be = 4'hf;
    endcase
  end
  // Register access must be word size, double-word aligned, supervisor except for trap flag reads,
  // end-of-init respected on writes, and no write to the trap flags
  wire [7:0] p_ofs     = LS_ADDR[7:0];
  wire       p_reg_ro  = p_ofs == `OFS_SYNC || p_ofs == `OFS_ASYNC;
  // Trap flag reads stay open to user mode so debuggers can peek [R14]
  wire       p_reg_bad = LS_SIZE != 2'd2 || LS_ADDR[2:0] != 3'd0 ||
                         (!LS_SUPER && !(p_reg_ro && !LS_WE)) ||
                         (LS_WE && !LS_ENDINIT_OK) ||
                         (LS_WE && p_reg_ro); // [R19]

  ////////////////////////////////////////////////////////////////////////
  // Bus slave checks: sel must be an aligned half-word or a word
  wire s_sel_ok = S_SEL_I == 4'hf ? S_ADR_I[1:0] == 2'd0 :
                  S_SEL_I == 4'h3 ? S_ADR_I[1:0] == 2'd0 :
                  S_SEL_I == 4'hc ? S_ADR_I[1:0] == 2'd2 : 1'b0; // [R1] [R2]
  // Privilege is not checked for bus slave accesses [R7]
  wire s_ok = s_sel_ok & hit_mem; // [R5]

  ////////////////////////////////////////////////////////////////////////
  // Memory port sharing
  wire        mem_go   = (p_take & hit_mem & ~range_err) | (s_take & s_ok);
  wire        mem_we   = p_take ? LS_WE : S_WE_I;
  wire [3:0]  mem_be   = p_take ? p_be : S_SEL_I;
  wire [31:0] mem_wd   = p_take ? LS_WDATA : S_DAT_I;
  wire        sram_en  = mem_go & hit_sram;
  wire        sby_en   = mem_go & hit_sby;
  wire [31:0] sram_rd;
  wire [31:0] sby_rd;

  dmu_ram #(.AW(`SRAM_AW)) u_sram (
    .clk   (CLK),
    .en    (sram_en),
    .we    (mem_we),
    .be    (mem_be),
    .addr  (d_addr[14:2]),
    .wdata (mem_wd),
    .rdata (sram_rd)
  );

  // Mirror by dropping address bits 14:13
  dmu_ram #(.AW(`SBY_AW)) u_sby (
    .clk   (CLK),
    .en    (sby_en),
    .we    (mem_we),
    .be    (mem_be),
    .addr  (d_addr[12:2]),
    .wdata (mem_wd),
    .rdata (sby_rd)
  ); // [R4]

  ////////////////////////////////////////////////////////////////////////
  // Trap flags: load events to sync register, store events to async
  wire       ld_range = p_take & ~LS_WE & range_err;
  wire       st_range = p_take & LS_WE & range_err;
  wire       ld_reg   = p_take & ~LS_WE & hit_regs & p_reg_bad;
  wire       st_reg   = p_take & LS_WE & hit_regs & p_reg_bad;
  wire       m_done   = state_q == ST_MST & (M_ACK_I | M_ERR_I);
  wire       ld_bus   = m_done & M_ERR_I & ~M_WE_O;
  wire       st_bus   = m_done & M_ERR_I & M_WE_O; // [R15]
  wire [5:0] ld_set   = {1'b0, ld_reg, 1'b0, ld_bus, 1'b0, ld_range};
  wire [5:0] st_set   = {st_reg, 1'b0, st_bus, 1'b0, st_range, 1'b0};
  // Same six-bit layout in both registers [R11]
  wire       rd_good  = p_take & hit_regs & ~p_reg_bad & ~LS_WE;
  wire       clr_sync = rd_good & LS_SUPER & p_ofs == `OFS_SYNC;
  wire       clr_async = rd_good & LS_SUPER & p_ofs == `OFS_ASYNC;
  wire [5:0] sync_q;
  wire [5:0] async_q;

  dmu_flags u_sync (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .set     (ld_set),
    .clr     (clr_sync),
    .flags_q (sync_q)
  ); // [R10] [R18]

  dmu_flags u_async (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .set     (st_set),
    .clr     (clr_async),
    .flags_q (async_q)
  ); // [R10] [R18]

  // Register read; user reads leave flags alone, reserved reads zero
  reg [31:0] reg_rd;
  always @* begin
    case (p_ofs)
      `OFS_CTRL:  reg_rd = {24'h000000, ctrl_q};
      `OFS_SYNC:  reg_rd = {26'h0, sync_q}; // [R13] [R14]
      `OFS_ASYNC: reg_rd = {26'h0, async_q};
      default:    reg_rd = 32'h00000000; // [R20]
    endcase
  end

  // Control register, a scratch byte; reserved writes ignored
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      ctrl_q <= `CTRL_RST;
    else if (p_take & hit_regs & ~p_reg_bad & LS_WE & p_ofs == `OFS_CTRL)
      ctrl_q <= LS_WDATA[7:0]; // [R20]
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (p_take)
          state_d = (local_hit || hit_regs) ?
                    (hit_mem && !range_err ? ST_PRD : ST_PDONE) :
                    ST_MST; // [R8]
        else if (s_take)
          state_d = s_ok ? ST_SRD : ST_SDONE;
      end
      ST_PRD:   state_d = ST_PDONE;
      ST_PDONE: state_d = ST_END;
      ST_SRD:   state_d = ST_SDONE;
      ST_SDONE: state_d = ST_END;
      ST_MST:   state_d = (M_ACK_I | M_ERR_I) ? ST_PDONE : ST_MST;
      ST_END:   state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // Outputs, captured request fields and lock tracking
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
      p_sel_sram_q <= 1'b0;
      p_lo_q <= 2'd0;
      p_size_q <= 2'd0;
      s_lock_q <= 1'b0;
      s_sel_sram_q <= 1'b0;
      LS_ACK <= 1'b0;
      LS_RDATA <= 32'h00000000;
      SYNC_TRAP <= 1'b0;
      ASYNC_TRAP <= 1'b0;
      S_DAT_O <= 32'h00000000;
      S_ACK_O <= 1'b0;
      S_ERR_O <= 1'b0;
      M_CYC_O <= 1'b0;
      M_STB_O <= 1'b0;
      M_WE_O <= 1'b0;
      M_ADR_O <= 32'h00000000;
      M_SEL_O <= 4'h0;
      M_DAT_O <= 32'h00000000;
    end else begin
      state_q <= state_d;
      LS_ACK <= 1'b0;
      S_ACK_O <= 1'b0;
      S_ERR_O <= 1'b0;
      SYNC_TRAP <= |ld_set; // [R12]
      ASYNC_TRAP <= |st_set; // [R12]
      // Locked sequence holds off processor until lock drops [R9]
      if (S_CYC_I & S_LOCK_I & (s_take | s_lock_q))
        s_lock_q <= 1'b1;
      else if (!S_CYC_I || !S_LOCK_I)
        s_lock_q <= 1'b0;
      if (p_take) begin
        p_sel_sram_q <= hit_sram;
        p_lo_q <= LS_ADDR[1:0];
        p_size_q <= LS_SIZE;
        if (hit_regs && !LS_WE)
          LS_RDATA <= p_reg_bad ? 32'h00000000 : reg_rd;
        else if (!hit_mem || range_err)
          LS_RDATA <= 32'h00000000;
        if (!local_hit && !hit_regs) begin
          M_CYC_O <= 1'b1; // [R8]
          M_STB_O <= 1'b1;
          M_WE_O <= LS_WE;
          M_ADR_O <= {LS_ADDR[31:2], 2'b00};
          M_SEL_O <= p_be;
          M_DAT_O <= LS_WDATA;
        end
      end
      if (s_take)
        s_sel_sram_q <= hit_sram;
      case (state_q)
        ST_PRD:
          LS_RDATA <= p_sel_sram_q ? sram_rd : sby_rd;
        ST_PDONE:
          LS_ACK <= 1'b1;
        ST_SRD: begin
          S_DAT_O <= s_sel_sram_q ? sram_rd : sby_rd;
          S_ACK_O <= 1'b1;
        end
        ST_SDONE:
          S_ERR_O <= ~S_ACK_O; // [R2] [R5]
        ST_MST: begin
          if (M_ACK_I | M_ERR_I) begin
            M_CYC_O <= 1'b0;
            M_STB_O <= 1'b0;
            LS_RDATA <= M_ERR_I ? 32'h00000000 : M_DAT_I;
          end
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verification/dmu_chk.sv ----
// Port assertions for the data memory unit
`default_nettype none
module dmu_chk (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        LS_REQ,
  input wire logic        LS_WE,
  input wire logic        LS_ACK,
  input wire logic [31:0] LS_ADDR,
  input wire logic        SYNC_TRAP,
  input wire logic        ASYNC_TRAP,
  input wire logic [31:0] S_ADR_I,
  input wire logic [3:0]  S_SEL_I,
  input wire logic        S_ACK_O,
  input wire logic        M_CYC_O,
  input wire logic        M_STB_O,
  input wire logic [31:0] M_ADR_O,
  input wire logic        M_ACK_I,
  input wire logic        M_ERR_I
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic sel_ok;
  logic resv13;
  // Legal slave lanes, and the unmapped part of segment 13
  assign sel_ok = (S_SEL_I == 4'hc) ? (S_ADR_I[1:0] == 2'h2) :
    (S_ADR_I[1:0] == 2'h0 && (S_SEL_I == 4'hf || S_SEL_I == 4'h3));
  assign resv13 = LS_ADDR[31:28] == 4'hd && LS_ADDR[27:16] != 12'h0 &&
    LS_ADDR[27:8] != 20'h7ffff;
  sequence s_bus_end;
    M_CYC_O && M_STB_O && (M_ACK_I || M_ERR_I);
  endsequence
  AST_SEL_OK: assert property (S_ACK_O |-> sel_ok)
    else $error("slave ack on bad lanes");
  AST_MEM_ONLY: assert property (S_ACK_O |-> S_ADR_I[31:16] == 16'hd000)
    else $error("slave ack outside memory");
  AST_LD_TRAP: assert property (SYNC_TRAP |-> LS_REQ && !LS_WE)
    else $error("sync trap without load");
  AST_ST_TRAP: assert property (ASYNC_TRAP |-> LS_REQ && LS_WE)
    else $error("async trap without store");
  AST_RANGE13: assert property (LS_ACK && resv13 |->
    $past(SYNC_TRAP) || $past(ASYNC_TRAP)) else $error("no range trap");
  AST_SEG9: assert property (LS_ACK && LS_ADDR[31:28] == 4'h9 |->
    $past(SYNC_TRAP) || $past(ASYNC_TRAP)) else $error("no segment 9 trap");
  AST_MST_OUT: assert property (M_CYC_O |-> LS_REQ && M_ADR_O == LS_ADDR &&
    LS_ADDR[31:28] != 4'h9 && LS_ADDR[31:28] != 4'hd)
    else $error("master cycle without outward request");
  AST_MST_END: assert property (s_bus_end |=> !M_CYC_O)
    else $error("master cycle held after answer");
endmodule
bind data_memory_unit dmu_chk u_dmu_chk (.*);
`default_nettype wire

// ---- verification/sysbus_target.sv ----
// Behavioural target on the far side of the master port
`default_nettype none
module sysbus_target (
  input  wire logic        CLK,
  input  wire logic        M_CYC_O,
  input  wire logic        M_STB_O,
  input  wire logic [31:0] M_ADR_O,
  output var  logic [31:0] M_DAT_I,
  output var  logic        M_ACK_I,
  output var  logic        M_ERR_I
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  // Waits adr[4:2] cycles; segment f faults; data flips on every cycle without an answer, wait cycles included
  always @(posedge CLK) begin
    M_ACK_I <= 1'b0;
    M_ERR_I <= 1'b0;
    M_DAT_I <= ~M_DAT_I;
    cnt_q <= 3'h0;
    if (M_CYC_O && M_STB_O && !M_ACK_I && !M_ERR_I) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == M_ADR_O[4:2]) begin
        M_ACK_I <= M_ADR_O[31:28] != 4'hf;
        M_ERR_I <= M_ADR_O[31:28] == 4'hf;
        M_DAT_I <= M_ADR_O ^ 32'h5a5a0000;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/data_memory_unit_bench.sv ----
// Self-checking bench for the data memory unit
`default_nettype none
`include "dmu_regs.vh"
module data_memory_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, ARST_N, LS_REQ, LS_WE, LS_SUPER, LS_ENDINIT_OK, LS_ACK;
  logic        SYNC_TRAP, ASYNC_TRAP, S_CYC_I, S_STB_I, S_WE_I, S_LOCK_I;
  logic        S_ACK_O, S_ERR_O, M_CYC_O, M_STB_O, M_WE_O, M_ACK_I, M_ERR_I;
  logic        trap, err;
  logic [1:0]  LS_SIZE;
  logic [3:0]  S_SEL_I, M_SEL_O;
  logic [15:0] sels;
  logic [31:0] LS_ADDR, LS_WDATA, LS_RDATA, S_ADR_I, S_DAT_I, S_DAT_O;
  logic [31:0] M_ADR_O, M_DAT_O, M_DAT_I, rd, seed, a;
  int          bad_count, comparisons, n;
  data_memory_unit u_data_memory_unit (.*);
  sysbus_target u_sysbus_target (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic bad_sel(input logic [3:0] s, input logic hi);
    return !((s == 4'hc && hi) || ((s == 4'h3 || s == 4'hf) && !hi));
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // A lost answer ends the run
  task automatic guard;
    if (n == 60) begin
      bad_count++;
      end_of_test();
    end
  endtask
  // Processor request held until the acknowledge edge
  task automatic ls(input logic [31:0] ad, wd, input logic w, s,
                    input logic [1:0] sz);
    @(posedge CLK);
    LS_REQ <= 1'b1;
    LS_WE <= w;
    LS_ADDR <= ad;
    LS_WDATA <= wd;
    LS_SUPER <= s;
    LS_SIZE <= sz;
    trap = 1'b0;
    for (n = 0; n < 60 && LS_ACK !== 1'b1; n++) begin
      @(posedge CLK);
      trap = trap | SYNC_TRAP | ASYNC_TRAP;
    end
    guard();
    rd = LS_RDATA;
    LS_REQ <= 1'b0;
  endtask
  task automatic rdf(input logic [7:0] o);
    ls(`REGS_BASE + {24'h0, o}, 32'h0, 1'b0, 1'b1, 2'h2);
  endtask
  // Classic single cycle, released after the answer edge
  task automatic wb(input logic [31:0] ad, wd, input logic w,
                    input logic [3:0] s);
    @(posedge CLK);
    S_CYC_I <= 1'b1;
    S_STB_I <= 1'b1;
    S_WE_I <= w;
    S_LOCK_I <= seed[3];
    S_ADR_I <= ad;
    S_DAT_I <= wd;
    S_SEL_I <= s;
    for (n = 0; n < 60 && S_ACK_O !== 1'b1 && S_ERR_O !== 1'b1; n++)
      @(posedge CLK);
    guard();
    rd = S_DAT_O;
    err = S_ERR_O;
    S_CYC_I <= 1'b0;
    S_STB_I <= 1'b0;
    S_LOCK_I <= 1'b0;
  endtask
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // Reset, memories, slave refusals, traps and flag registers
  initial begin
    {ARST_N, LS_REQ, LS_WE, LS_SUPER, S_CYC_I, S_STB_I, S_WE_I} = '0;
    {S_LOCK_I, LS_ADDR, LS_WDATA, S_ADR_I, S_DAT_I, S_SEL_I} = '0;
    LS_SIZE = 2'h2;
    LS_ENDINIT_OK = 1'b1;
    sels = 16'hfc31;
    seed = 32'had1a;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    rdf(`OFS_SYNC);
    chk("sync_reset", 32'h0, rd);
    rdf(`OFS_ASYNC);
    chk("async_reset", 32'h0, rd);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      a = {16'hd000, seed[15:2], 2'h0};
      ls(a, seed, 1'b1, seed[4], 2'h2);
      if (a[15])
        a[14:13] = k[1:0];
      wb(a, 32'h0, 1'b0, 4'hf);
      chk("bus_read", seed, rd);
      wb(a, ~seed, 1'b1, 4'h3);
      ls(a, 32'h0, 1'b0, seed[5], 2'h2);
      chk("half_write", {seed[31:16], ~seed[15:0]}, rd);
      wb(`SRAM_BASE | {30'h0, k[2], 1'b0}, 32'h0, 1'b0, sels[4*k[1:0] +: 4]);
      chk("slave_err", bad_sel(sels[4*k[1:0] +: 4], k[2]), err);
    end
    wb(32'hd0010000, 32'h0, 1'b1, 4'hf);
    chk("bus_reserved", 32'h1, err);
    ls(32'hd0010000, 32'h0, 1'b0, 1'b1, 2'h2);
    chk("range_trap", 32'h1, trap);
    ls(32'h90000000, seed, 1'b1, 1'b1, 2'h2);
    chk("seg9_trap", 32'h1, trap);
    ls(`REGS_BASE + `OFS_SYNC, 32'h0, 1'b0, 1'b0, 2'h2);
    chk("user_read", 32'h1, rd | {31'h0, trap});
    rdf(`OFS_SYNC);
    chk("sync_range", 32'h1, rd[`BIT_LD_RANGE]);
    rdf(`OFS_SYNC);
    chk("sync_clear", 32'h0, rd);
    rdf(`OFS_ASYNC);
    chk("async_range", 32'h1 << `BIT_ST_RANGE, rd);
    ls(32'h40000014, 32'h0, 1'b0, 1'b1, 2'h2);
    chk("out_read", 32'h1a5a0014, rd);
    ls(32'hf0000000, 32'h0, 1'b0, 1'b1, 2'h2);
    chk("bus_load_trap", 32'h1, trap);
    ls(32'hf0000004, seed, 1'b1, 1'b1, 2'h2);
    ls(`REGS_BASE + `OFS_CTRL, 32'h0, 1'b0, 1'b1, 2'h0);
    chk("reg_trap", 32'h1, trap);
    ls(`REGS_BASE + `OFS_SYNC, seed, 1'b1, 1'b1, 2'h2);
    ls(`REGS_BASE + 32'h30, 32'h0, 1'b0, 1'b1, 2'h2);
    chk("reserved_reg", 32'h0, rd | {31'h0, trap});
    rdf(`OFS_SYNC);
    chk("sync_flags", 32'h14, rd);
    rdf(`OFS_ASYNC);
    chk("async_flags", 32'h28, rd);
    end_of_test();
  end
endmodule
`default_nettype wire
